// >>> hw/pcr_framer.sv
// Partition configuration response framer: sends the payload fields as a byte stream.
// Assumes a query pulse from the command decoder and a byte sink with valid and ready.
`timescale 1ns/1ps
module pcr_framer #(
    parameter int ADDR_W = 64,
    parameter int VF_W = 16
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Query request and status.
    input wire logic query_req,
    output logic busy,
    output logic [7:0] resp_code,
    // Host driver and link reporting.
    input wire logic drv_present,
    input wire logic drv_report_spt,
    input wire logic link_report_spt,
    // Boot state.
    input wire logic boot_configured,
    input wire logic boot_supported,
    // Traffic capability terms.
    input wire logic host_bus_assigned,
    input wire logic sideband_assigned,
    input wire logic port_link_up,
    input wire logic inter_partition_ok,
    output logic traffic_capable,
    // Bandwidth shares and function count.
    input wire logic [7:0] transmit_share_ceiling,
    input wire logic [7:0] transmit_share_committed,
    input wire logic [VF_W-1:0] vf_count,
    // Addresses; cur_en marks current addresses in use.
    input wire logic [7:0] cur_en,
    input wire logic [7:0][ADDR_W-1:0] perm_addr,
    input wire logic [7:0][ADDR_W-1:0] cur_addr,
    // Payload byte stream.
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    input wire logic out_ready
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pcr_pkg::pcr_phase_type phase_r;
        logic [2:0] fix_idx_r;
        logic [3:0] entry_r;
        logic [3:0] byte_r;
        logic valid_r;
        logic [7:0] data_r;
        logic last_r;
        logic [7:0] resp_r;
        logic [pcr_pkg::FLAGS_W-1:0] flags_r;
        logic [7:0] ceil_r;
        logic [7:0] commit_r;
        logic [VF_W-1:0] vf_r;
        logic [7:0] cur_en_r;
        logic [7:0] addr_cnt_r;
    } pcr_state_type;

    localparam pcr_state_type ST_RST = '{
        phase_r: pcr_pkg::PH_IDLE,
        resp_r: pcr_pkg::RESP_CODE_RST,
        default: '0
    };

    pcr_state_type st_r;
    pcr_state_type st_nxt;
    logic advance;
    logic [4:0] nxt_entry;

    pcr_tlv_if tlv ();

    // ************************************************************
    // Helper functions
    // ************************************************************
    // Bandwidth values above full rate are held at full rate.
    function automatic logic [7:0] pct_clamp(input logic [7:0] v);
        pct_clamp = (v > pcr_pkg::PCT_MAX) ? pcr_pkg::PCT_MAX : v;
    endfunction

    // Number of entries: all permanent ones plus each current one in use.
    function automatic logic [7:0] count_entries(input logic [7:0] en);
        logic [7:0] c;
        c = 8'(pcr_pkg::N_TYPES);
        for (int i = 0; i < 8; i++) begin
            c = c + {7'h00, en[i]};
        end
        count_entries = c;
    endfunction

    // Next entry to send after entry e, or none.
    function automatic logic [4:0] next_entry(input logic [3:0] e, input logic [7:0] en);
        logic [4:0] n;
        n = pcr_pkg::ENTRY_NONE;
        for (int i = 15; i >= 0; i--) begin
            if (i > int'(e) && (i < 8 || en[i % 8])) begin
                n = 5'(i);
            end
        end
        next_entry = n;
    endfunction

    // Fixed payload byte at index idx, most significant byte of a field first.
    function automatic logic [7:0] fixed_byte(input pcr_state_type s, input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            pcr_pkg::IDX_FLAGS_HI: b = s.flags_r[15:8];
            pcr_pkg::IDX_FLAGS_LO: b = s.flags_r[7:0];
            pcr_pkg::IDX_CEILING: b = s.ceil_r;
            pcr_pkg::IDX_COMMITTED: b = s.commit_r;
            pcr_pkg::IDX_VF_HI: b = 8'(s.vf_r >> 8);
            pcr_pkg::IDX_VF_LO: b = s.vf_r[7:0];
            pcr_pkg::IDX_FC: b = pcr_pkg::FC_BYTE;
            pcr_pkg::IDX_ADDR_CNT: b = s.addr_cnt_r;
        endcase
        fixed_byte = b;
    endfunction

    // ************************************************************
    // Traffic capability
    // ************************************************************
    // A partition carries traffic only when placed on a bus and a channel and it has a path.
    assign traffic_capable = host_bus_assigned && sideband_assigned
                             && (port_link_up || inter_partition_ok);

    // ************************************************************
    // Address entry generator
    // ************************************************************
    assign tlv.entry = st_r.entry_r;
    assign tlv.byte_idx = st_r.byte_r;
    assign nxt_entry = next_entry(st_r.entry_r, st_r.cur_en_r);

    pcr_tlv_gen #(
        .ADDR_W(ADDR_W)
    ) u_tlv_gen (
        .clk(clk),
        .rst_n(rst_n),
        .tlv(tlv.gen),
        .perm_addr(perm_addr),
        .cur_addr(cur_addr)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    // A new byte is loaded when the output holds none or the sink takes the current one.
    always_comb begin
        st_nxt = st_r;
        advance = !st_r.valid_r || out_ready;
        if (advance) begin
            st_nxt.valid_r = 1'b0;
            st_nxt.last_r = 1'b0;
        end
        unique case (st_r.phase_r)
            pcr_pkg::PH_IDLE: begin
                // Snapshot every field except the address values, which the generator reads live while entries go out.
                if (query_req) begin
                    st_nxt.phase_r = pcr_pkg::PH_FIXED;
                    st_nxt.fix_idx_r = pcr_pkg::IDX_FLAGS_HI;
                    st_nxt.resp_r = pcr_pkg::RESP_CODE;
                    st_nxt.flags_r = '0;
                    st_nxt.flags_r[pcr_pkg::FLAG_DRV_PRESENT] = drv_report_spt && drv_present;
                    st_nxt.flags_r[pcr_pkg::FLAG_DRV_SPT] = drv_report_spt;
                    st_nxt.flags_r[pcr_pkg::FLAG_LINK_UP] = link_report_spt && traffic_capable;
                    st_nxt.flags_r[pcr_pkg::FLAG_LINK_SPT] = link_report_spt;
                    st_nxt.flags_r[pcr_pkg::FLAG_BOOT_CFG] = boot_configured;
                    st_nxt.flags_r[pcr_pkg::FLAG_BOOT_NOT_SPT] = !boot_supported;
                    st_nxt.ceil_r = pct_clamp(transmit_share_ceiling);
                    st_nxt.commit_r = pct_clamp(transmit_share_committed);
                    st_nxt.vf_r = vf_count;
                    st_nxt.cur_en_r = cur_en;
                    st_nxt.addr_cnt_r = count_entries(cur_en);
                end
            end
            pcr_pkg::PH_FIXED: begin
                if (advance) begin
                    st_nxt.valid_r = 1'b1;
                    st_nxt.data_r = fixed_byte(st_r, st_r.fix_idx_r);
                    if (st_r.fix_idx_r == pcr_pkg::IDX_ADDR_CNT) begin
                        st_nxt.phase_r = pcr_pkg::PH_TLV;
                        st_nxt.entry_r = 4'h0;
                        st_nxt.byte_r = 4'h0;
                    end else begin
                        st_nxt.fix_idx_r = st_r.fix_idx_r + 3'h1;
                    end
                end
            end
            pcr_pkg::PH_TLV: begin
                if (advance) begin
                    st_nxt.valid_r = 1'b1;
                    st_nxt.data_r = tlv.data;
                    if (tlv.last) begin
                        st_nxt.byte_r = 4'h0;
                        if (nxt_entry == pcr_pkg::ENTRY_NONE) begin
                            st_nxt.last_r = 1'b1;
                            st_nxt.phase_r = pcr_pkg::PH_IDLE;
                        end else begin
                            st_nxt.entry_r = nxt_entry[3:0];
                        end
                    end else begin
                        st_nxt.byte_r = st_r.byte_r + 4'h1;
                    end
                end
            end
            // A phase code that is not one-hot drops back to idle rather than locking up.
            default: begin
                st_nxt.phase_r = pcr_pkg::PH_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    // The clock enable freezes every framer register, stream handshake included, but not the combinational traffic_capable output.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ST_RST;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign busy = (st_r.phase_r != pcr_pkg::PH_IDLE);
    assign resp_code = st_r.resp_r;
    assign out_valid = st_r.valid_r;
    assign out_data = st_r.data_r;
    assign out_last = st_r.last_r;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    resp_code_a: assert property ((ce && !busy && query_req) |=> (busy && resp_code == 8'hAB))
        else $error("Query did not start a response with code AB.");
    drv_flags_a: assert property ((ce && !busy && query_req) |=>
        (st_r.flags_r[0] == ($past(drv_present) && $past(drv_report_spt))))
        else $error("Driver present flag does not follow the driver inputs.");
    drv_spt_a: assert property ((ce && !busy && query_req) |=> (st_r.flags_r[1] == $past(drv_report_spt)))
        else $error("Driver reporting flag wrong.");
    link_flag_a: assert property ((ce && !busy && query_req) |=>
        (st_r.flags_r[2] == ($past(link_report_spt) && $past(traffic_capable))))
        else $error("Link up flag does not follow link state.");
    link_spt_a: assert property ((ce && !busy && query_req) |=> (st_r.flags_r[3] == $past(link_report_spt)))
        else $error("Link reporting flag wrong.");
    boot_flags_a: assert property ((ce && !busy && query_req) |=>
        (st_r.flags_r[4] == $past(boot_configured) && st_r.flags_r[5] != $past(boot_supported)))
        else $error("Boot flags wrong or not inverted.");
    flags_rsvd_a: assert property (busy |-> (st_r.flags_r[15:6] == 10'h000))
        else $error("Reserved flag bits set.");
    traffic_a: assert property (traffic_capable |-> (host_bus_assigned && sideband_assigned))
        else $error("Traffic capable without bus and channel.");
    share_range_a: assert property (busy |-> (st_r.ceil_r <= 8'h64 && st_r.commit_r <= 8'h64))
        else $error("Bandwidth share above full rate.");
    addr_count_a: assert property (busy |-> (st_r.addr_cnt_r == 8'(8 + $countones(st_r.cur_en_r))))
        else $error("Address count does not match the entries sent.");
    fc_zero_a: assert property ((ce && advance && st_r.phase_r == pcr_pkg::PH_FIXED && st_r.fix_idx_r == 3'h6)
        |=> (out_valid && out_data == 8'h00))
        else $error("Fibre channel byte not zero.");

    // A byte that the sink has not taken stays put, and so does the code between queries.
    hold_stall_a: assert property ((out_valid && !(ce && out_ready)) |=>
        (out_valid && $stable(out_data) && $stable(out_last)))
        else $error("Stream byte changed before the sink took it.");
    resp_hold_a: assert property (!(ce && !busy && query_req) |=> $stable(resp_code))
        else $error("Response code changed without a query.");
    query_refused_a: assert property ((busy && query_req) |=>
        ($stable(st_r.flags_r) && $stable(st_r.vf_r) && $stable(st_r.addr_cnt_r)))
        else $error("Query taken while a response was in progress.");
    last_valid_a: assert property (out_last |-> out_valid)
        else $error("Last marker without a byte.");

    // The snapshot of each field follows the inputs present at the accepted query.
    ceil_snap_a: assert property ((ce && !busy && query_req) |=>
        (st_r.ceil_r == (($past(transmit_share_ceiling) > 8'h64) ? 8'h64 : $past(transmit_share_ceiling))))
        else $error("Ceiling share not taken or not clamped.");
    commit_snap_a: assert property ((ce && !busy && query_req) |=>
        (st_r.commit_r == (($past(transmit_share_committed) > 8'h64) ? 8'h64 : $past(transmit_share_committed))))
        else $error("Committed share not taken or not clamped.");
    vf_snap_a: assert property ((ce && !busy && query_req) |=> (st_r.vf_r == $past(vf_count)))
        else $error("Function count not taken from the query.");

    // A current entry is only ever sent for an address that is in use.
    cur_entry_a: assert property ((st_r.phase_r == pcr_pkg::PH_TLV && st_r.entry_r[3]) |->
        st_r.cur_en_r[st_r.entry_r[2:0]])
        else $error("Current address entry sent for an address not in use.");

    // The first entry after the fixed bytes is always the first permanent type.
    perm_first_a: assert property ((ce && advance && st_r.phase_r == pcr_pkg::PH_FIXED
        && st_r.fix_idx_r == pcr_pkg::IDX_ADDR_CNT) |=> (st_r.phase_r == pcr_pkg::PH_TLV && st_r.entry_r == 4'h0))
        else $error("Address entries did not start with the first permanent type.");

endmodule

// >>> include/pcr_pkg.sv
// Constants, field layout and phase codes of the partition configuration response framer.
// Assumes a single core clock domain; every user writes pcr_pkg::name.
package pcr_pkg;

    // ************************************************************
    // Codes and field positions
    // ************************************************************
    localparam logic [7:0] RESP_CODE = 8'hAB;
    localparam logic [7:0] RESP_CODE_RST = 8'h00;
    localparam int FLAG_DRV_PRESENT = 0;
    localparam int FLAG_DRV_SPT = 1;
    localparam int FLAG_LINK_UP = 2;
    localparam int FLAG_LINK_SPT = 3;
    localparam int FLAG_BOOT_CFG = 4;
    localparam int FLAG_BOOT_NOT_SPT = 5;
    localparam int FLAGS_W = 16;
    localparam logic [7:0] PCT_MAX = 8'h64;
    localparam logic [7:0] FC_BYTE = 8'h00;

    // ************************************************************
    // Fixed part of the payload, in send order
    // ************************************************************
    localparam logic [2:0] IDX_FLAGS_HI = 3'h0;
    localparam logic [2:0] IDX_FLAGS_LO = 3'h1;
    localparam logic [2:0] IDX_CEILING = 3'h2;
    localparam logic [2:0] IDX_COMMITTED = 3'h3;
    localparam logic [2:0] IDX_VF_HI = 3'h4;
    localparam logic [2:0] IDX_VF_LO = 3'h5;
    localparam logic [2:0] IDX_FC = 3'h6;
    localparam logic [2:0] IDX_ADDR_CNT = 3'h7;

    // ************************************************************
    // Address entries
    // ************************************************************
    localparam int N_TYPES = 8;
    localparam logic [7:0] PERM_TYPE_BASE = 8'h01;
    localparam logic [7:0] CUR_TYPE_BASE = 8'hF1;
    localparam logic [4:0] ENTRY_NONE = 5'h10;
    localparam logic [3:0] TLV_HDR_BYTES = 4'h2;
    // Address bytes per type: two MACs, two names, FIP MAC, two GUIDs, vport.
    localparam logic [0:7][7:0] ADDR_LEN = {8'h06, 8'h06, 8'h08, 8'h08, 8'h06, 8'h08, 8'h08, 8'h04};

    // ************************************************************
    // Framer phases
    // ************************************************************
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_FIXED = 3'b010,
        PH_TLV = 3'b100
    } pcr_phase_type;

endpackage

// >>> include/pcr_tlv_if.sv
// Lookup path between the response framer and its address entry generator.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
interface pcr_tlv_if;
    logic [3:0] entry;
    logic [3:0] byte_idx;
    logic [7:0] data;
    logic last;

    modport walker (output entry, output byte_idx, input data, input last);
    modport gen (input entry, input byte_idx, output data, output last);
endinterface

// >>> hw/pcr_tlv_gen.sv
// Address entry generator: turns an entry number and byte number into one payload byte.
// Assumes the framer holds entry and byte number steady while it samples the byte.
`timescale 1ns/1ps
module pcr_tlv_gen #(
    parameter int ADDR_W = 64
) (
    // Clock and reset, used only for checking.
    input wire logic clk,
    input wire logic rst_n,
    // Lookup path.
    pcr_tlv_if.gen tlv,
    // Permanent and current address values, right aligned.
    input wire logic [7:0][ADDR_W-1:0] perm_addr,
    input wire logic [7:0][ADDR_W-1:0] cur_addr
);

    logic [7:0] len;
    logic [7:0] etype;
    logic [3:0] k;
    logic [ADDR_W-1:0] word;

    // ************************************************************
    // Byte selection
    // ************************************************************
    // Entries 0 to 7 are permanent, 8 to 15 current, both in the same type order.
    always_comb begin
        len = pcr_pkg::ADDR_LEN[tlv.entry[2:0]];
        etype = (tlv.entry[3] ? pcr_pkg::CUR_TYPE_BASE : pcr_pkg::PERM_TYPE_BASE)
                + {5'h00, tlv.entry[2:0]};
        word = tlv.entry[3] ? cur_addr[tlv.entry[2:0]] : perm_addr[tlv.entry[2:0]];
        k = 4'(len[3:0] - 4'h1 - (tlv.byte_idx - pcr_pkg::TLV_HDR_BYTES));
        // The 16-bit header goes high byte first: length, then type.
        if (tlv.byte_idx == 4'h0) begin
            tlv.data = len;
        end else if (tlv.byte_idx == 4'h1) begin
            tlv.data = etype;
        end else begin
            tlv.data = word[{k[2:0], 3'b000} +: 8];
        end
        tlv.last = (tlv.byte_idx == 4'(len[3:0] + 4'h1));
    end

    // ************************************************************
    // Checks
    // ************************************************************
    type_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
        (tlv.byte_idx == 4'h1) |-> ((tlv.data >= 8'h01 && tlv.data <= 8'h08)
                                  || (tlv.data >= 8'hF1 && tlv.data <= 8'hF8)))
        else $error("Address entry type outside the defined codes.");

endmodule

// >>> verif/pcr_sink_model.sv
// Sink model of the management controller end of the response byte stream.
// Assumes the bench watches transfers itself; this model only paces out_ready.
`timescale 1ns/1ps
module pcr_sink_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pacing choice and ready back to the framer.
    input wire logic stall_en,
    output logic out_ready
);
    integer seed = 98;

    // Ready stays high when prompt, or is drawn at random so the framer must hold its byte.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall_en || ($random(seed) % 3 == 0);
        end
    end
endmodule

// >>> verif/pcr_framer_tb.sv
// Self-checking bench for the partition configuration response framer.
// Assumes pcr_pkg, the framer and the sink model are compiled before it.
`timescale 1ns/1ps
module partition_config_response_fields_tb;
    // ************************************************************
    // Signals, expectations and counters
    // ************************************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic ce_rand = 1'b0;
    logic query_req = 1'b0;
    logic stall_en = 1'b0;
    logic drv_present, drv_report_spt, link_report_spt, boot_configured, boot_supported;
    logic host_bus_assigned, sideband_assigned, port_link_up, inter_partition_ok;
    logic [7:0] transmit_share_ceiling, transmit_share_committed, cur_en;
    logic [15:0] vf_count;
    logic [7:0][63:0] perm_addr, cur_addr;
    logic busy, traffic_capable, out_valid, out_last, out_ready;
    logic [7:0] resp_code, out_data;
    logic [8:0] exp_q[$];
    logic [7:0] edge_tbl [4] = '{8'h64, 8'h65, 8'hFF, 8'h00};
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    integer seed = 98;

    pcr_framer #(.ADDR_W(64), .VF_W(16)) dut (.clk(clk), .rst_n(rst_n), .ce(ce), .query_req(query_req),
        .busy(busy), .resp_code(resp_code), .drv_present(drv_present), .drv_report_spt(drv_report_spt),
        .link_report_spt(link_report_spt), .boot_configured(boot_configured), .boot_supported(boot_supported),
        .host_bus_assigned(host_bus_assigned), .sideband_assigned(sideband_assigned),
        .port_link_up(port_link_up), .inter_partition_ok(inter_partition_ok), .traffic_capable(traffic_capable),
        .transmit_share_ceiling(transmit_share_ceiling), .transmit_share_committed(transmit_share_committed),
        .vf_count(vf_count), .cur_en(cur_en), .perm_addr(perm_addr), .cur_addr(cur_addr),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

    pcr_sink_model sink (.clk(clk), .rst_n(rst_n), .stall_en(stall_en), .out_ready(out_ready));

    // ************************************************************
    // Clock, enable, timeout and helpers
    // ************************************************************
    // The clock toggles every half period of 10 ns.
    always #10 clk = ~clk;

    // The enable drops at random when asked, freezing the framer for a cycle.
    always @(posedge clk) begin
        ce <= !ce_rand || ($random(seed) % 4 != 0);
    end

    // A hung run is cut short and counted as a failure.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Shares above one hundred percent are expected to be clamped.
    function automatic logic [7:0] pct(input logic [7:0] v);
        return (v > 8'h64) ? 8'h64 : v;
    endfunction

    // ************************************************************
    // Expected stream and scoreboard
    // ************************************************************
    // Builds the byte list of one response from the inputs held for it.
    task automatic expect_query();
        logic [15:0] fl;
        logic [63:0] a;
        int len;
        fl = 16'h0000;
        fl[0] = drv_present & drv_report_spt;
        fl[1] = drv_report_spt;
        fl[2] = link_report_spt & host_bus_assigned & sideband_assigned & (port_link_up | inter_partition_ok);
        fl[3] = link_report_spt;
        fl[4] = boot_configured;
        fl[5] = !boot_supported;
        exp_q.push_back({1'b0, fl[15:8]});
        exp_q.push_back({1'b0, fl[7:0]});
        exp_q.push_back({1'b0, pct(transmit_share_ceiling)});
        exp_q.push_back({1'b0, pct(transmit_share_committed)});
        exp_q.push_back({1'b0, vf_count[15:8]});
        exp_q.push_back({1'b0, vf_count[7:0]});
        exp_q.push_back(9'h000);
        exp_q.push_back({1'b0, 8'($countones(cur_en) + 8)});
        for (int e = 0; e < 16; e++) begin
            if (e < 8 || cur_en[e % 8]) begin
                len = int'(pcr_pkg::ADDR_LEN[e % 8]);
                a = (e < 8) ? perm_addr[e % 8] : cur_addr[e % 8];
                exp_q.push_back({1'b0, 8'(len)});
                exp_q.push_back({1'b0, (e < 8) ? 8'(e + 1) : 8'(8'hF1 + e - 8)});
                for (int b = len - 1; b >= 0; b--) begin
                    exp_q.push_back({1'b0, a[b * 8 +: 8]});
                end
            end
        end
        exp_q[exp_q.size() - 1][8] = 1'b1;
    endtask

    // Every accepted byte is compared with the oldest note; a byte with no note is wrong.
    always @(posedge clk) begin
        if (rst_n && ce && out_valid && out_ready) begin
            if (exp_q.size() == 0) begin
                check({7'h00, out_last, out_data}, 16'hFFFF);
            end else begin
                check({7'h00, out_last, out_data}, {7'h00, exp_q.pop_front()});
            end
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    // One query with edge or random field values, optional stalls and a refused second query.
    task automatic run_query(input int q);
        logic [31:0] r;
        int k;
        @(posedge clk);
        r = $random(seed);
        {drv_present, drv_report_spt, link_report_spt, boot_configured, boot_supported} <= r[4:0];
        {host_bus_assigned, sideband_assigned, port_link_up, inter_partition_ok} <= r[8:5];
        transmit_share_ceiling <= (q < 4) ? edge_tbl[q] : r[16:9];
        transmit_share_committed <= (q < 4) ? edge_tbl[3 - q] : r[24:17];
        cur_en <= (q == 0) ? 8'h00 : (q == 1) ? 8'hFF : 8'($random(seed));
        vf_count <= 16'($random(seed));
        for (int i = 0; i < 8; i++) begin
            perm_addr[i] <= {$random(seed), $random(seed)};
            cur_addr[i] <= {$random(seed), $random(seed)};
        end
        stall_en <= q[0];
        ce_rand <= (q >= 6);
        query_req <= 1'b1;
        @(negedge clk);
        expect_query();
        k = 0;
        while (busy !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        query_req <= 1'b0;
        check({8'h00, resp_code}, {8'h00, pcr_pkg::RESP_CODE});
        if (q == 2) begin
            @(posedge clk);
            query_req <= 1'b1;
            @(posedge clk);
            query_req <= 1'b0;
        end
        k = 0;
        while ((busy !== 1'b0 || out_valid !== 1'b0 || exp_q.size() != 0) && k < 2000) begin
            @(posedge clk);
            k++;
        end
        check(16'(exp_q.size()), 16'h0000);
    endtask

    // Main sequence: reset, capability table, then a run of queries.
    initial begin
        {drv_present, drv_report_spt, link_report_spt, boot_configured, boot_supported} = 5'h00;
        {host_bus_assigned, sideband_assigned, port_link_up, inter_partition_ok} = 4'h0;
        {transmit_share_ceiling, transmit_share_committed, cur_en, vf_count} = 40'h0;
        perm_addr = '0;
        cur_addr = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({6'h00, busy, out_valid, resp_code}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {host_bus_assigned, sideband_assigned, port_link_up, inter_partition_ok} <= i[3:0];
            @(negedge clk);
            check({15'h0000, traffic_capable}, {15'h0000, i[3] & i[2] & (i[1] | i[0])});
        end
        for (int q = 0; q < 12; q++) begin
            run_query(q);
        end
        report_and_stop();
    end
endmodule
